// ===== icu_pkg.sv
/*
  Shared constants for the input capture unit: register offsets, control
  field positions, mode codes and buffer geometry.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package icu_pkg;
  // Register byte offsets.
  localparam logic [7:0] ICU_CTRL_OFF   = 8'h00;
  localparam logic [7:0] ICU_BUF_OFF    = 8'h04;
  localparam logic [7:0] ICU_STAT_OFF   = 8'h08;
  localparam logic [7:0] ICU_MASK_OFF   = 8'h0C;
  // Control field positions.
  localparam int ICU_ON_BIT    = 15;
  localparam int ICU_IDLE_STOP_BIT  = 13;
  localparam int ICU_FIRST_EDGE_SELECT_BIT = 9;
  localparam int ICU_WIDE_BIT  = 8;
  localparam int ICU_TSEL_BIT  = 7;
  localparam int ICU_ICI_LSB   = 5;
  localparam int ICU_OV_BIT    = 4;
  localparam int ICU_BNE_BIT   = 3;
  localparam int ICU_MODE_LSB  = 0;
  // Writable control bits.
  localparam logic [31:0] ICU_CTRL_WMASK = 32'h0000A3E7;
  localparam logic [31:0] ICU_CTRL_RST   = 32'h00000000;
  // Status bits: event, overflow.
  localparam int ICU_ST_EVT = 0;
  localparam int ICU_ST_OV  = 1;
  localparam logic [1:0] ICU_STAT_RST = 2'h0;
  // Buffer geometry.
  localparam int ICU_DEPTH = 4;
  localparam int ICU_AW    = 2;
  // Prescaler terminal counts.
  localparam logic [3:0] ICU_PRE4  = 4'h3;
  localparam logic [3:0] ICU_PRE16 = 4'hF;
  typedef enum logic [2:0]
  {
    ICU_M_OFF   = 3'h0,
    ICU_M_EDGE  = 3'h1,
    ICU_M_FALL  = 3'h2,
    ICU_M_RISE  = 3'h3,
    ICU_M_PRE4  = 3'h4,
    ICU_M_PRE16 = 3'h5,
    ICU_M_EVERY = 3'h6,
    ICU_M_INT   = 3'h7
  } icu_mode_type;
endpackage

// ===== icu_mem.sv
/*
  Small capture buffer memory with registered read data.
  Assumes one clock; write and read may occur in the same cycle.
*/
`timescale 1ns/10ps
module icu_mem
  import icu_pkg::*;
(
  // Clock.
  input  wire logic                 pclk,
  // Write side.
  input  wire logic                 we,
  input  wire logic [ICU_AW-1:0]    waddr,
  input  wire logic [31:0]          wdata,
  // Read side.
  input  wire logic [ICU_AW-1:0]    raddr,
  output logic      [31:0]          rdata
);
  logic [31:0] mem [ICU_DEPTH];

  // Storage and registered read; no reset needed on the array.
  always_ff @(posedge pclk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

// ===== icu_top.sv
/*
  Input capture unit with APB register access, capture buffer and interrupt.
  Assumes the capture pin and idle request are asynchronous, the timers are
  on pclk, and the APB master follows the usual setup/access protocol.
*/
// Overview of operation
// - Enable bit cleared holds unit in reset, blocks interrupts, control stays writable.
// - Idle-stop set halts the unit during processor Idle; clear keeps running.
// - In mode 110 the first-edge bit picks rising (1) or falling (0) first.
// - Wide select captures the 32-bit timer; clear captures a 16-bit timer.
// - In 16-bit capture timer select picks first (1) or second (0) timer.
// - Events-per-interrupt field interrupts after every 1st to 4th capture.
// - Read-only overflow flag reads 1 after a capture overflow.
// - Read-only buffer-not-empty flag reads 1 while captures wait.
// - Mode 111 interrupts on input activity only in Sleep or Idle.
// - Mode 110 captures every edge, starting with the selected polarity.
// - Mode 101 captures every sixteenth rising edge via a prescaler.
// - Mode 100 captures every fourth rising edge via a prescaler.
// - Mode 011 captures on every rising edge.
// - Mode 010 captures on every falling edge.
// - Mode 001 captures on every edge from the first one.
// - Mode 000 takes no captures.
`timescale 1ns/10ps
module icu_top
  import icu_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Capture input and timers.
  input  wire logic        capture_pin,
  input  wire logic [15:0] timer_x,
  input  wire logic [15:0] timer_y,
  input  wire logic [31:0] timer_wide,
  // Power state.
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  // Interrupt.
  output logic             irq
);
  import icu_pkg::*;

  logic [31:0]       ctrl_reg;
  logic [1:0]        stat_reg;
  logic [1:0]        mask_reg;
  logic              pin_s1_reg, pin_s2_reg, pin_d_reg;
  logic              idle_s1_reg, idle_s2_reg, sleep_s1_reg, sleep_s2_reg;
  logic [3:0]        pre_reg;
  logic [1:0]        evt_cnt_reg;
  logic              first_done_reg;
  logic [ICU_AW:0]   wptr_reg, rptr_reg;
  logic              ov_reg;
  logic [31:0]       rdata;

  // Decoded control fields.
  logic              on, idle_stop, first_edge_select, wide, tsel;
  logic [1:0]        events_per_interrupt;
  icu_mode_type      mode;
  assign on    = ctrl_reg[ICU_ON_BIT];
  assign idle_stop  = ctrl_reg[ICU_IDLE_STOP_BIT];
  assign first_edge_select = ctrl_reg[ICU_FIRST_EDGE_SELECT_BIT];
  assign wide  = ctrl_reg[ICU_WIDE_BIT];
  assign tsel  = ctrl_reg[ICU_TSEL_BIT];
  assign events_per_interrupt   = ctrl_reg[ICU_ICI_LSB +: 2];
  assign mode  = icu_mode_type'(ctrl_reg[ICU_MODE_LSB +: 3]);

  function automatic logic is_off(input logic [31:0] a, input logic [7:0] o);
    is_off = (a[7:0] == o);
  endfunction

  // APB phase decode; every access completes in its first access cycle.
  logic wr_acc, rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // Two-flop synchronisers for the pin and power-state inputs.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      idle_s1_reg  <= 1'b0;
      idle_s2_reg  <= 1'b0;
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg   <= capture_pin;
      pin_s2_reg   <= pin_s1_reg;
      idle_s1_reg  <= cpu_idle;
      idle_s2_reg  <= idle_s1_reg;
      sleep_s1_reg <= cpu_sleep;
      sleep_s2_reg <= sleep_s1_reg;
    end
  end

  // The unit runs only while enabled and not stopped by Idle.
  logic run;
  assign run = on && !(idle_stop && idle_s2_reg);

  // Edge history is kept running so re-enable does not see a false edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_d_reg <= 1'b0;
    else
      pin_d_reg <= pin_s2_reg;
  end

  logic rise, fall;
  assign rise = run && pin_s2_reg && !pin_d_reg;
  assign fall = run && !pin_s2_reg && pin_d_reg;

  // Capture event decode per mode.
  logic cap_evt, int_only_evt;
  always_comb
  begin
    cap_evt      = 1'b0;
    int_only_evt = 1'b0;
    case (mode)
      ICU_M_OFF:   cap_evt = 1'b0;
      ICU_M_EDGE:  cap_evt = rise || fall;
      ICU_M_FALL:  cap_evt = fall;
      ICU_M_RISE:  cap_evt = rise;
      ICU_M_PRE4:  cap_evt = rise && (pre_reg[1:0] == ICU_PRE4[1:0]);
      ICU_M_PRE16: cap_evt = rise && (pre_reg == ICU_PRE16);
      ICU_M_EVERY: cap_evt = first_done_reg ? (rise || fall)
                                            : (first_edge_select ? rise : fall);
      ICU_M_INT:   int_only_evt = (rise || fall) && (idle_s2_reg || sleep_s2_reg);
      default:     cap_evt = 1'b0;
    endcase
  end

  // Prescaler counts rising edges; cleared while disabled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_reg <= 4'h0;
    else if (!on)
      pre_reg <= 4'h0;
    else if (rise)
      pre_reg <= pre_reg + 4'h1;
  end

  // First-edge tracker for mode 110; a mode change re-arms it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_done_reg <= 1'b0;
    else if (!on || mode != ICU_M_EVERY)
      first_done_reg <= 1'b0;
    else if (cap_evt)
      first_done_reg <= 1'b1;
  end

  // Timer selection for the captured value.
  logic [31:0] cap_val;
  assign cap_val = wide ? timer_wide
                        : {16'h0000, tsel ? timer_x : timer_y};

  // Buffer pointers; a read of the buffer register pops the oldest entry.
  logic full, empty, push, pop;
  assign empty = (wptr_reg == rptr_reg);
  assign full  = (wptr_reg[ICU_AW-1:0] == rptr_reg[ICU_AW-1:0]) &&
                 (wptr_reg[ICU_AW] != rptr_reg[ICU_AW]);
  assign push  = cap_evt && !full;
  assign pop   = rd_acc && is_off({24'h0, paddr}, ICU_BUF_OFF) && !empty;

  // Pointers carry one extra bit so that full and empty can be told apart.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else if (!on)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else
    begin
      if (push)
        wptr_reg <= wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= rptr_reg + 1'b1;
    end
  end

  // Overflow is sticky until the module is disabled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ov_reg <= 1'b0;
    else if (!on)
      ov_reg <= 1'b0;
    else if (cap_evt && full)
      ov_reg <= 1'b1;
  end

  // On a pop the read address steps one entry ahead, so a read straight
  // after a pop still finds the next entry in the memory's output register.
  logic [ICU_AW-1:0] raddr_next;
  always_comb
  begin
    raddr_next = rptr_reg[ICU_AW-1:0];
    if (pop)
      raddr_next = rptr_reg[ICU_AW-1:0] + ICU_AW'(1);
  end

  // Read address looks ahead so memory data is ready in the next read's setup cycle.
  icu_mem u_mem
  (
    .pclk  (pclk),
    .we    (push),
    .waddr (wptr_reg[ICU_AW-1:0]),
    .wdata (cap_val),
    .raddr (raddr_next),
    .rdata (rdata)
  );

  // A capture written into the slot being read shows up at the memory's output
  // one cycle late; a copy is held for that cycle so a quick read is not stale.
  logic        byp_reg;
  logic [31:0] byp_data_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byp_reg      <= 1'b0;
      byp_data_reg <= 32'h0;
    end
    else
    begin
      byp_reg      <= push && (wptr_reg[ICU_AW-1:0] == raddr_next);
      byp_data_reg <= cap_val;
    end
  end

  // Event counter paces interrupts by the events-per-interrupt field.
  logic int_evt;
  assign int_evt = (cap_evt && (evt_cnt_reg == events_per_interrupt)) || int_only_evt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_cnt_reg <= 2'h0;
    else if (!on)
      evt_cnt_reg <= 2'h0;
    else if (cap_evt)
      evt_cnt_reg <= (evt_cnt_reg == events_per_interrupt) ? 2'h0 : evt_cnt_reg + 2'h1;
  end

  // Control register; writable at any time, read-only flags not stored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= ICU_CTRL_RST;
    else if (wr_acc && is_off({24'h0, paddr}, ICU_CTRL_OFF))
      ctrl_reg <= pwdata & ICU_CTRL_WMASK;
  end

  // Sticky status: set wins over a write-one-to-clear in the same cycle.
  logic [1:0] stat_set, stat_clr;
  assign stat_set = {on && cap_evt && full, on && int_evt};
  assign stat_clr = (wr_acc && is_off({24'h0, paddr}, ICU_STAT_OFF)) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_reg <= ICU_STAT_RST;
    else
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
  end

  // Interrupt mask, laid out like the status register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_reg <= 2'h0;
    else if (wr_acc && is_off({24'h0, paddr}, ICU_MASK_OFF))
      mask_reg <= pwdata[1:0];
  end

  // Interrupt is held low while disabled, since software may be reconfiguring.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= on && |(stat_reg & mask_reg);
  end

  // Read mux: flags are live state of the buffer.
  logic [31:0] ctrl_view, rd_mux;
  logic        hit;
  always_comb
  begin
    ctrl_view = ctrl_reg;
    ctrl_view[ICU_OV_BIT]  = ov_reg;
    ctrl_view[ICU_BNE_BIT] = !empty;
    hit    = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      ICU_CTRL_OFF: rd_mux = ctrl_view;
      ICU_BUF_OFF:  rd_mux = empty ? 32'h0 : (byp_reg ? byp_data_reg : rdata);
      ICU_STAT_OFF: rd_mux = {30'h0, stat_reg};
      ICU_MASK_OFF: rd_mux = {30'h0, mask_reg};
      default:      hit = 1'b0;
    endcase
  end

  // Registered APB outputs; unmapped addresses answer with an error.
  // Read data are taken in the setup cycle, so no access needs a wait state;
  // the price is that a read shows the state as it stood in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end
endmodule

// ===== icu_checker.sv
/*
  Port-level checker for the input capture unit.
  Assumes it is bound to icu_top and sees only its APB and interrupt ports.
*/
`timescale 1ns/10ps
module icu_checker
  import icu_pkg::*;
(
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt.
  input wire logic        irq
);
  logic [31:0] ctl_q;
  logic [1:0]  msk_q;
  logic        wr;
  logic        setup;
  logic        mapped;
  logic        on;
  assign wr = psel && penable && pready && pwrite;
  assign setup = psel && !penable;
  assign mapped = paddr inside {ICU_CTRL_OFF, ICU_BUF_OFF, ICU_STAT_OFF, ICU_MASK_OFF};
  assign on = ctl_q[ICU_ON_BIT];
  // Shadows of what software wrote, so enable and mask can be referred to.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q <= ICU_CTRL_RST;
      msk_q <= 2'h0;
    end
    else if (wr && paddr == ICU_CTRL_OFF)
      ctl_q <= pwdata & ICU_CTRL_WMASK;
    else if (wr && paddr == ICU_MASK_OFF)
      msk_q <= pwdata[1:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
  a_ready_cause: assert property ($rose(pready) |-> $past(setup))
    else $error("pready without a setup cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_ctrl_readback: assert property (setup && !pwrite && paddr == ICU_CTRL_OFF |=>
    (prdata & ~32'h00000018) == ctl_q) else $error("control readback wrong");
  a_off_flags_clear: assert property (setup && !pwrite && paddr == ICU_CTRL_OFF
    && !on && !$past(on) |=> prdata[4:3] == 2'h0) else $error("flags kept while off");
  a_off_no_irq: assert property (!on && !$past(on) |-> !irq)
    else $error("interrupt while disabled");
  a_irq_masked: assert property ($past(msk_q) == 2'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_bne: cover property (pready && paddr == ICU_CTRL_OFF && prdata[ICU_BNE_BIT]);
  c_ovf: cover property (pready && paddr == ICU_CTRL_OFF && prdata[ICU_OV_BIT]);
endmodule

bind icu_top icu_checker u_chk (.*);

// ===== icu_src_model.sv
/*
  Far-side model: the capture pin and the three timer sources.
  Assumes the bench sets the pin level and a timer seed off the clock edge.
*/
`timescale 1ns/10ps
module icu_src_model
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench controls.
  input  wire logic        pin_in,
  input  wire logic [15:0] seed,
  // Toward the unit.
  output logic             capture_pin,
  output logic      [15:0] timer_x,
  output logic      [15:0] timer_y,
  output logic      [31:0] timer_wide
);
  // Timers hold the seed so a capture value never depends on exact latency.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_x <= 16'h0000;
    else
      timer_x <= seed;
  end
  assign timer_y = ~timer_x;
  assign timer_wide = {timer_x, 16'h5A5A};
  // The pin changes on a clock edge, as a pad driven by another pclk block would.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_pin <= 1'b0;
    else
      capture_pin <= pin_in;
  end
endmodule

// ===== icu_top_tb.sv
/*
  Self-checking bench for the input capture unit: mode table, then hand tests.
  Assumes zero-wait APB answers are still waited for under a timeout.
*/
`timescale 1ns/10ps
module icu_top_tb;
  import icu_pkg::*;
  typedef struct packed {logic [31:0] ctl; logic [7:0] n; logic [7:0] c; logic [31:0] v;}
    icu_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, capture_pin;
  logic pin_in, cpu_idle, cpu_sleep;
  logic [7:0] paddr;
  logic [15:0] seed, timer_x, timer_y;
  logic [31:0] pwdata, prdata, timer_wide, rd;
  int error_cnt, n_checks, cyc;
  icu_row_type rows [8] = '{
    '{32'h00008101, 8'h04, 8'h04, 32'h12345A5A}, '{32'h00008082, 8'h06, 8'h03, 32'h00001234},
    '{32'h00008003, 8'h06, 8'h03, 32'h0000EDCB}, '{32'h00008084, 8'h10, 8'h02, 32'h00001234},
    '{32'h00008085, 8'h20, 8'h01, 32'h00001234}, '{32'h00008086, 8'h04, 8'h03, 32'h00001234},
    '{32'h00008286, 8'h04, 8'h04, 32'h00001234}, '{32'h00008080, 8'h04, 8'h00, 32'h00001234}};
  icu_top DUT (.*);
  icu_src_model u_src (.*);
  // Free-running clock and a cycle ceiling against hangs.
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; read data lands in rd, the error flag is checked against err.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic err = 1'b0);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", err, pslverr);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic edg(int n);
    repeat (n)
    begin
      @(posedge pclk);
      pin_in <= ~pin_in;
      repeat (6) @(posedge pclk);
    end
  endtask
  task automatic restart(logic [31:0] c);
    apb(1, ICU_CTRL_OFF, 0);
    apb(1, ICU_STAT_OFF, 3);
    apb(1, ICU_CTRL_OFF, c);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, pin_in, cpu_idle, cpu_sleep} = 0;
    {paddr, pwdata} = 0;
    seed = 16'h1234;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a < 16; a += 4)
    begin
      apb(0, 8'(a), 0);
      chk("reset value", 0, rd);
    end
    apb(0, 8'h10, 0, 1);
    chk("unmapped read", 0, rd);
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      restart(rows[i].ctl);
      edg(rows[i].n);
      apb(0, ICU_CTRL_OFF, 0);
      chk("not empty", rows[i].c != 0, rd[ICU_BNE_BIT]);
      chk("overflow", 0, rd[ICU_OV_BIT]);
      repeat (rows[i].c)
      begin
        apb(0, ICU_BUF_OFF, 0);
        chk("capture", rows[i].v, rd);
      end
      apb(0, ICU_CTRL_OFF, 0);
      chk("drained", 0, rd[ICU_BNE_BIT]);
      $display("row %0d done", i);
    end
    restart(32'h00008101);
    for (int k = 1; k < 7; k++)
    begin
      seed <= 16'(k);
      edg(1);
    end
    apb(0, ICU_CTRL_OFF, 0);
    chk("overflow set", 1, rd[ICU_OV_BIT]);
    for (int k = 1; k < 3; k++)
    begin
      apb(0, ICU_BUF_OFF, 0);
      chk("oldest first", {16'(k), 16'h5A5A}, rd);
    end
    apb(1, ICU_CTRL_OFF, 0);
    apb(0, ICU_CTRL_OFF, 0);
    chk("flags after off", 0, rd[4:3]);
    apb(0, ICU_BUF_OFF, 0);
    chk("buffer after off", 0, rd);
    $display("overflow test done");
    apb(1, ICU_MASK_OFF, 1);
    for (int j = 0; j < 4; j++)
    begin
      restart(32'h00008003 | (j << ICU_ICI_LSB));
      edg(2 * j);
      chk("irq early", 0, irq);
      edg(2);
      chk("irq due", 1, irq);
      apb(1, ICU_STAT_OFF, 1);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 0, irq);
    end
    apb(1, ICU_MASK_OFF, 0);
    restart(32'h00008003);
    edg(2);
    chk("irq masked", 0, irq);
    apb(0, ICU_STAT_OFF, 0);
    chk("status sticky", 1, rd);
    apb(1, ICU_MASK_OFF, 1);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 1, irq);
    apb(1, ICU_CTRL_OFF, 0);
    repeat (2) @(posedge pclk);
    chk("irq while off", 0, irq);
    $display("interrupt test done");
    cpu_idle <= 1;
    restart(32'h0000A003);
    edg(2);
    apb(0, ICU_CTRL_OFF, 0);
    chk("idle halted", 0, rd[ICU_BNE_BIT]);
    restart(32'h00008003);
    edg(2);
    apb(0, ICU_CTRL_OFF, 0);
    chk("idle running", 1, rd[ICU_BNE_BIT]);
    cpu_idle <= 0;
    restart(32'h00008007);
    edg(2);
    apb(0, ICU_STAT_OFF, 0);
    chk("int-only awake", 0, rd[ICU_ST_EVT]);
    cpu_sleep <= 1;
    edg(2);
    apb(0, ICU_STAT_OFF, 0);
    chk("int-only asleep", 1, rd[ICU_ST_EVT]);
    $display("power test done");
    restart(32'h00008003);
    edg(2);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    chk("irq after reset", 0, irq);
    apb(0, ICU_CTRL_OFF, 0);
    chk("ctrl after reset", 0, rd);
    apb(0, ICU_MASK_OFF, 0);
    chk("mask after reset", 0, rd);
    $display("reset test done");
    wrap_up;
  end
endmodule
